// *** core/ticcs_top.sv ***
/*
  Timer channel 0 capture edge select and channel 1 compare/capture
  function select, with capture, compare, general registers and interrupt.
  Assumes pins synchronous to CLK_IN and an AXI4-Lite master.
*/
`timescale 1ns/100ps
module ticcs_top
  import ticcs_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // AXI4-Lite write
  input wire logic AXI_AWVALID_IN,
  input wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic AXI_WVALID_IN,
  input wire logic [DATA_W-1:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  output logic AXI_WREADY_OUT,
  output logic AXI_BVALID_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_BREADY_IN,
  // AXI4-Lite read
  input wire logic AXI_ARVALID_IN,
  input wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
  output logic AXI_ARREADY_OUT,
  output logic AXI_RVALID_OUT,
  output logic [DATA_W-1:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  input wire logic AXI_RREADY_IN,
  // Channel 0 capture pins and channel 10 counter B match
  input wire logic [CH0_LANES-1:0] CH0_PIN_IN,
  input wire logic CH10_MATCH_IN,
  // Channel 1 two-way pins
  input wire logic [CH1_LANES-1:0] CH1_PIN_IN,
  output logic [CH1_LANES-1:0] CH1_PIN_OUT,
  output logic [CH1_LANES-1:0] CH1_PIN_OE_N_OUT,
  // Standby levels and interrupt
  input wire logic STANDBY_HW_IN,
  input wire logic STANDBY_SW_IN,
  output logic IRQ_OUT
);
  ticcs_regbus_if bus ();

  logic [7:0] ch0_sel_q, ch0_sel_d;
  logic [CH1_REGS-1:0][7:0] ch1_ctl_q, ch1_ctl_d;
  logic [CH1_LANES-1:0][CNT_W-1:0] gr_q, gr_d;
  logic [CH0_LANES-1:0][CNT_W-1:0] icr_q, icr_d;
  logic [CNT_W-1:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d;
  logic [CH1_LANES-1:0] pin_q, pin_d, oe_n_q, oe_n_d;
  logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic irq_q, irq_d;
  logic [CH1_LANES-1:0][2:0] fld;
  logic [2*CH1_LANES-1:0] ch1_edge_sel;
  logic [CH1_LANES-1:0] ch1_cap, ch1_cm;
  logic [CH0_LANES-1:0] ch0_cap, ch0_load;
  logic [CH1_REGS-1:0] rsvd;
  logic [DATA_W-1:0] rd_word;

  // Assertion clock and reset for every check in this module
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  // Bus slave
  ticcs_axil_slave u_slave (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .awvalid_in(AXI_AWVALID_IN),
    .awaddr_in(AXI_AWADDR_IN),
    .awready_out(AXI_AWREADY_OUT),
    .wvalid_in(AXI_WVALID_IN),
    .wdata_in(AXI_WDATA_IN),
    .wstrb_in(AXI_WSTRB_IN),
    .wready_out(AXI_WREADY_OUT),
    .bvalid_out(AXI_BVALID_OUT),
    .bresp_out(AXI_BRESP_OUT),
    .bready_in(AXI_BREADY_IN),
    .arvalid_in(AXI_ARVALID_IN),
    .araddr_in(AXI_ARADDR_IN),
    .arready_out(AXI_ARREADY_OUT),
    .rvalid_out(AXI_RVALID_OUT),
    .rdata_out(AXI_RDATA_OUT),
    .rresp_out(AXI_RRESP_OUT),
    .rready_in(AXI_RREADY_IN),
    .bus(bus.slave)
  );

  // Channel 0 pin edges, two select bits per pin
  ticcs_edge_det #(.LANES(CH0_LANES)) u_ch0_edge (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(CH0_PIN_IN),
    .sel_in(ch0_sel_q),
    .evt_out(ch0_cap)
  );

  // Channel 1 pin edges, only in capture mode
  ticcs_edge_det #(.LANES(CH1_LANES)) u_ch1_edge (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(CH1_PIN_IN),
    .sel_in(ch1_edge_sel),
    .evt_out(ch1_cap)
  );

  // Per general register field decode
  for (genvar g = 0; g < CH1_LANES; g++) begin : g_gr
    assign fld[g] = ch1_ctl_q[g/2][(g%2)*CH1_FLD_HI_POS +: CH1_FLD_W];
    assign ch1_edge_sel[2*g +: 2] = fld[g][2] ? fld[g][1:0] : EDGE_OFF;
    assign ch1_cm[g] = !fld[g][2] && (fld[g] != FN_CMP_OFF) && (cnt1_q == gr_q[g]);

    AST_CMP_LEVEL: assert property ((ch1_cm[g] && fld[g] != FN_CMP_TOG) |=>
      (CH1_PIN_OUT[g] == $past(fld[g][1]))) else $error("compare level wrong");
    AST_CMP_TOGGLE: assert property ((ch1_cm[g] && fld[g] == FN_CMP_TOG) |=>
      (CH1_PIN_OUT[g] != $past(CH1_PIN_OUT[g]))) else $error("compare toggle missing");
    AST_CMP_OFF_HOLD: assert property ((fld[g] == FN_CMP_OFF) |=>
      $stable(CH1_PIN_OUT[g]) && !CH1_PIN_OE_N_OUT[g]) else $error("disabled compare moved pin");
    AST_CAP_RISE: assert property ((fld[g] == FN_CAP_RISE && CH1_PIN_IN[g] &&
      !$past(CH1_PIN_IN[g]) && !$past(RESET_IN)) |=> (gr_q[g] == $past(cnt1_q)))
      else $error("rising capture missed");
    AST_CAP_NOWRITE: assert property ((fld[g][2] && !ch1_cap[g]) |=>
      $stable(gr_q[g])) else $error("general register changed in capture mode");
  end

  // Reserved bit watch
  for (genvar r = 0; r < CH1_REGS; r++) begin : g_rsvd
    assign rsvd[r] = ch1_ctl_q[r][7] || ch1_ctl_q[r][3];
  end

  // Channel 0 loads: pin edges, plus counter B match on D while D is off
  assign ch0_load = ch0_cap | {CH10_MATCH_IN && (ch0_sel_q[7:6] == EDGE_OFF), 3'h0};

  // Address checks and read mux
  assign bus.wr_err = (bus.wr_addr[1:0] != 2'h0) || (bus.wr_addr > OFS_IRQ_MASK);
  assign bus.rd_err = (bus.rd_addr[1:0] != 2'h0) || (bus.rd_addr > OFS_IRQ_MASK);
  assign bus.rd_data = rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (bus.rd_addr == OFS_CH0_SEL) begin
      rd_word[7:0] = ch0_sel_q;
    end
    for (int i = 0; i < CH1_REGS; i++) begin
      if (bus.rd_addr == OFS_CH1_CTL + 8'(4*i)) begin
        rd_word[7:0] = ch1_ctl_q[i] & CH1_CTL_WMASK;
      end
    end
    for (int i = 0; i < CH1_LANES; i++) begin
      if (bus.rd_addr == OFS_GR + 8'(4*i)) begin
        rd_word[CNT_W-1:0] = gr_q[i];
      end
    end
    for (int i = 0; i < CH0_LANES; i++) begin
      if (bus.rd_addr == OFS_ICR + 8'(4*i)) begin
        rd_word[CNT_W-1:0] = icr_q[i];
      end
    end
    if (bus.rd_addr == OFS_CNT0) begin
      rd_word[CNT_W-1:0] = cnt0_q;
    end
    if (bus.rd_addr == OFS_CNT1) begin
      rd_word[CNT_W-1:0] = cnt1_q;
    end
    if (bus.rd_addr == OFS_IRQ_STAT) begin
      rd_word[IRQ_W-1:0] = stat_q;
    end
    if (bus.rd_addr == OFS_IRQ_MASK) begin
      rd_word[IRQ_W-1:0] = mask_q;
    end
  end

  // Control registers: software writes; standby clears the channel 0 and 1 selects, not the mask
  always_comb begin
    ch0_sel_d = ch0_sel_q;
    ch1_ctl_d = ch1_ctl_q;
    mask_d = mask_q;
    if (bus.wr_en) begin
      if (bus.wr_addr == OFS_CH0_SEL && bus.wr_strb[0]) begin
        ch0_sel_d = bus.wr_data[7:0];
      end
      for (int i = 0; i < CH1_REGS; i++) begin
        if (bus.wr_addr == OFS_CH1_CTL + 8'(4*i) && bus.wr_strb[0]) begin
          ch1_ctl_d[i] = bus.wr_data[7:0] & CH1_CTL_WMASK;
        end
      end
      if (bus.wr_addr == OFS_IRQ_MASK) begin
        mask_d = IRQ_W'(ticcs_merge16({4'h0, mask_q}, bus.wr_data, bus.wr_strb));
      end
    end
    if (STANDBY_HW_IN || STANDBY_SW_IN) begin
      ch0_sel_d = CH0_SEL_RST;
      ch1_ctl_d = {CH1_REGS{CH1_CTL_RST}};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ch0_sel_q <= CH0_SEL_RST;
      ch1_ctl_q <= {CH1_REGS{CH1_CTL_RST}};
      mask_q <= IRQ_RST;
    end else begin
      ch0_sel_q <= ch0_sel_d;
      ch1_ctl_q <= ch1_ctl_d;
      mask_q <= mask_d;
    end
  end

  // Counters, general and capture registers
  always_comb begin
    cnt0_d = cnt0_q + 16'h0001;
    cnt1_d = cnt1_q + 16'h0001;
    gr_d = gr_q;
    icr_d = icr_q;
    for (int i = 0; i < CH1_LANES; i++) begin
      if (bus.wr_en && !fld[i][2] && bus.wr_addr == OFS_GR + 8'(4*i)) begin
        gr_d[i] = ticcs_merge16(gr_q[i], bus.wr_data, bus.wr_strb);
      end
      if (ch1_cap[i]) begin
        gr_d[i] = cnt1_q;
      end
    end
    for (int i = 0; i < CH0_LANES; i++) begin
      if (ch0_load[i]) begin
        icr_d[i] = cnt0_q;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      cnt0_q <= CNT_RST;
      cnt1_q <= CNT_RST;
      gr_q <= {CH1_LANES{GR_RST}};
      icr_q <= {CH0_LANES{CNT_RST}};
    end else begin
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
      gr_q <= gr_d;
      icr_q <= icr_d;
    end
  end

  // Channel 1 pin level and direction
  always_comb begin
    pin_d = pin_q;
    oe_n_d = oe_n_q;
    for (int i = 0; i < CH1_LANES; i++) begin
      oe_n_d[i] = fld[i][2];
      if (ch1_cm[i]) begin
        if (fld[i] == FN_CMP_TOG) begin
          pin_d[i] = !pin_q[i];
        end else begin
          pin_d[i] = fld[i][1];
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      pin_q <= '0;
      oe_n_q <= '0;
    end else begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Interrupt status: set wins over write-one clear
  always_comb begin
    stat_d = stat_q;
    if (bus.wr_en && bus.wr_addr == OFS_IRQ_STAT) begin
      stat_d = stat_q & ~IRQ_W'(ticcs_merge16(16'h0000, bus.wr_data, bus.wr_strb));
    end
    stat_d[CH0_IRQ_POS +: CH0_LANES] = stat_d[CH0_IRQ_POS +: CH0_LANES] | ch0_load;
    stat_d[CH1_IRQ_POS +: CH1_LANES] = stat_d[CH1_IRQ_POS +: CH1_LANES] | ch1_cap | ch1_cm;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      stat_q <= IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  assign CH1_PIN_OUT = pin_q;
  assign CH1_PIN_OE_N_OUT = oe_n_q;
  assign IRQ_OUT = irq_q;

  // Checks on capture selection, standby and interrupt
  AST_CH0D_RISE: assert property ((ch0_sel_q[7:6] == EDGE_RISE && CH0_PIN_IN[3] &&
    !$past(CH0_PIN_IN[3]) && !$past(RESET_IN)) |=> (icr_q[3] == $past(cnt0_q)))
    else $error("capture D missed rising edge");
  AST_CH0D_MATCH: assert property ((ch0_sel_q[7:6] == EDGE_OFF && CH10_MATCH_IN) |=>
    (icr_q[3] == $past(cnt0_q))) else $error("counter B match did not load D");
  AST_CH0D_OFF: assert property ((ch0_sel_q[7:6] == EDGE_OFF && !CH10_MATCH_IN) |=>
    $stable(icr_q[3])) else $error("capture D loaded while off");
  AST_CH0C_FALL: assert property ((ch0_sel_q[5:4] == EDGE_FALL && !CH0_PIN_IN[2] &&
    $past(CH0_PIN_IN[2]) && !$past(RESET_IN)) |=> (icr_q[2] == $past(cnt0_q)))
    else $error("capture C missed falling edge");
  AST_CH0B_IDLE: assert property ((ch0_sel_q[3:2] == EDGE_OFF) |=> $stable(icr_q[1]))
    else $error("capture B loaded while off");
  AST_CH0A_BOTH: assert property ((ch0_sel_q[1:0] == EDGE_BOTH &&
    CH0_PIN_IN[0] != $past(CH0_PIN_IN[0]) && !$past(RESET_IN)) |=> (icr_q[0] == $past(cnt0_q)))
    else $error("capture A missed an edge");
  AST_STBY_CLEAR: assert property ((STANDBY_HW_IN || STANDBY_SW_IN) |=>
    (ch1_ctl_q == '0) && (ch0_sel_q == CH0_SEL_RST)) else $error("standby did not clear controls");
  AST_RSVD_ZERO: assert property (rsvd == '0) else $error("reserved control bit set");
  AST_IRQ_LEVEL: assert property (IRQ_OUT == |(stat_q & mask_q)) else $error("interrupt level wrong");
endmodule

// *** core/ticcs_pkg.sv ***
/*
  Constants and helpers shared by the channel 0/1 timer I/O select block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package ticcs_pkg;
  // Widths and lane counts
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int CH0_LANES = 4;
  localparam int CH1_LANES = 8;
  localparam int CH1_REGS = 4;
  localparam int IRQ_W = 12;

  // Register byte offsets
  localparam logic [7:0] OFS_CH0_SEL = 8'h00;
  localparam logic [7:0] OFS_CH1_CTL = 8'h04;
  localparam logic [7:0] OFS_GR = 8'h14;
  localparam logic [7:0] OFS_ICR = 8'h34;
  localparam logic [7:0] OFS_CNT0 = 8'h44;
  localparam logic [7:0] OFS_CNT1 = 8'h48;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h4C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h50;

  // Field positions and writable bits
  localparam int CH1_FLD_W = 3;
  localparam int CH1_FLD_HI_POS = 4;
  localparam logic [7:0] CH1_CTL_WMASK = 8'h77;
  localparam int CH0_IRQ_POS = 0;
  localparam int CH1_IRQ_POS = 4;

  // Reset values
  localparam logic [7:0] CH0_SEL_RST = 8'h00;
  localparam logic [7:0] CH1_CTL_RST = 8'h00;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [11:0] IRQ_RST = 12'h000;

  // Edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Channel 1 function codes
  localparam logic [2:0] FN_CMP_OFF = 3'h0;
  localparam logic [2:0] FN_CMP_TOG = 3'h3;
  localparam logic [2:0] FN_CAP_RISE = 3'h5;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] ticcs_merge16(logic [15:0] old, logic [31:0] d, logic [3:0] s);
    ticcs_merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
endpackage

// *** core/ticcs_regbus_if.sv ***
/*
  Register access strobes between the AXI4-Lite slave and the register file.
  Assumes one clock; read data is combinational from the register side.
*/
`timescale 1ns/100ps
interface ticcs_regbus_if;
  import ticcs_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_err;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_err, rd_data, rd_err);
endinterface

// *** core/ticcs_edge_det.sv ***
/*
  Per-lane pin edge detector with a 2-bit select per lane.
  Assumes pins synchronous to the clock; event is combinational.
*/
`timescale 1ns/100ps
module ticcs_edge_det
  import ticcs_pkg::*;
#(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins and selects
  input wire logic [LANES-1:0] pin_in,
  input wire logic [2*LANES-1:0] sel_in,
  // Edge events
  output logic [LANES-1:0] evt_out
);
  logic [LANES-1:0] prev_q;
  logic [LANES-1:0] prev_d;

  // Previous pin level
  always_comb begin
    prev_d = pin_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Low select bit takes rising, high bit falling
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign evt_out[g] = (sel_in[2*g] && pin_in[g] && !prev_q[g]) ||
                        (sel_in[2*g+1] && !pin_in[g] && prev_q[g]);
  end
endmodule

// *** core/ticcs_axil_slave.sv ***
/*
  AXI4-Lite slave: takes address and data in either order, one write
  and one read at a time. Assumes the register side decodes combinationally.
*/
`timescale 1ns/100ps
module ticcs_axil_slave
  import ticcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Write address and data
  input wire logic awvalid_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  output logic awready_out,
  input wire logic wvalid_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic wready_out,
  // Write response
  output logic bvalid_out,
  output logic [1:0] bresp_out,
  input wire logic bready_in,
  // Read
  input wire logic arvalid_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  output logic arready_out,
  output logic rvalid_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  input wire logic rready_in,
  // Register side
  ticcs_regbus_if.slave bus
);
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic do_wr;

  // Handshake next state
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    do_wr = aw_have_q && w_have_q && !bvalid_q;
    if (awvalid_in && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = awaddr_in;
    end
    if (wvalid_in && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = wdata_in;
      wstrb_d = wstrb_in;
    end
    if (bvalid_q && bready_in) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = bus.wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid_q && rready_in) begin
      rvalid_d = 1'b0;
    end
    if (arvalid_in && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d = bus.rd_data;
      rresp_d = bus.rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      wstrb_q <= wstrb_d;
    end
  end

  // Register side strobes and bus outputs
  assign bus.wr_en = do_wr;
  assign bus.wr_addr = awaddr_q;
  assign bus.wr_data = wdata_q;
  assign bus.wr_strb = wstrb_q;
  assign bus.rd_addr = araddr_in;
  assign awready_out = awready_q;
  assign wready_out = wready_q;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign arready_out = arready_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;
endmodule

// *** verif/ticcs_pin_model.sv ***
/*
  Far-side pin model for the eight channel 1 two-way pins.
  Assumes the block drives a lane while its enable is low.
*/
`timescale 1ns/100ps
module ticcs_pin_model (
  // Block side
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] oe_n_in,
  // Far-side drive level
  input wire logic [7:0] drive_in,
  // Resolved wire level
  output logic [7:0] level_out
);
  // A lane shows the block's level while it drives, else the far-side level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level_out[i] = oe_n_in[i] ? drive_in[i] : pin_out_in[i];
    end
  end
endmodule

// *** verif/testbench.sv ***
/*
  Self-checking bench: AXI4-Lite master tasks, pin stimulus and an integer
  model of captures, compare outputs, status and control registers.
  Assumes the top module, package and pin model are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  import ticcs_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic c10 = 0, sb_hw = 0, sb_sw = 0, awr, wr, bv, arr, rv, irq;
  logic [7:0] awa = 0, ara = 0, p1_drv = 0, p1_in, p1_out, p1_oen;
  logic [31:0] wd = 0, rdat;
  logic [3:0] p0 = 0;
  logic [1:0] br, rr, resp;
  int num_errors = 0, checks_done = 0, cyc = 0, seed = 32'ha01d;

  ticcs_top ticcs_top_i (.CLK_IN(clk), .RESET_IN(rst), .AXI_AWVALID_IN(awv), .AXI_AWADDR_IN(awa),
    .AXI_AWREADY_OUT(awr), .AXI_WVALID_IN(wv), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hF),
    .AXI_WREADY_OUT(wr), .AXI_BVALID_OUT(bv), .AXI_BRESP_OUT(br), .AXI_BREADY_IN(bre),
    .AXI_ARVALID_IN(arv), .AXI_ARADDR_IN(ara), .AXI_ARREADY_OUT(arr), .AXI_RVALID_OUT(rv),
    .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr), .AXI_RREADY_IN(rre), .CH0_PIN_IN(p0),
    .CH10_MATCH_IN(c10), .CH1_PIN_IN(p1_in), .CH1_PIN_OUT(p1_out), .CH1_PIN_OE_N_OUT(p1_oen),
    .STANDBY_HW_IN(sb_hw), .STANDBY_SW_IN(sb_sw), .IRQ_OUT(irq));
  ticcs_pin_model ticcs_pin_model_i (.pin_out_in(p1_out), .oe_n_in(p1_oen), .drive_in(p1_drv),
    .level_out(p1_in));

  // Clock and cycle count; the count moves off the driving edge
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // Verdict and end of run
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw, b;
    da = 0;
    dw = 0;
    b = 0;
    @(posedge clk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    bre <= 1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awr && !da;
      tw = wr && !dw;
      @(posedge clk);
      if (ta) begin
        da = 1;
        awv <= 0;
      end
      if (tw) begin
        dw = 1;
        wv <= 0;
      end
    end
    while (!b) begin
      @(negedge clk);
      b = bv;
      resp = br;
      @(posedge clk);
    end
    bre <= 0;
  endtask

  // Bus read
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    logic g;
    g = 0;
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rre <= 1;
    while (!g) begin
      @(negedge clk);
      g = arr;
      @(posedge clk);
    end
    arv <= 0;
    g = 0;
    while (!g) begin
      @(negedge clk);
      g = rv;
      d = rdat;
      resp = rr;
      @(posedge clk);
    end
    rre <= 0;
  endtask

  // Read and compare
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    axr(a, x);
    chk(nm, x, e);
  endtask

  // Main sequence
  initial begin
    int i, r, k, tm, tr, tf, off, t, e;
    int cd[4];
    logic [31:0] v, sel, st;
    logic [31:0] base[4], cap[4];
    repeat (5) @(posedge clk);
    rst <= 0;
    off = -cyc; // Counters read zero in the cycle after release
    rc("sel_rst", OFS_CH0_SEL, 0);
    for (i = 0; i < 4; i++) rc("ctl_rst", 8'(OFS_CH1_CTL + 4 * i), 0);
    rc("gr_rst", OFS_GR, 32'(GR_RST));
    axr(8'h54, v);
    chk("bad_rd_resp", 32'(resp), 32'(RESP_SLVERR));
    axw(8'h54, 32'h0000_00ff);
    chk("bad_wr_resp", 32'(resp), 32'(RESP_SLVERR));
    // Random control values, then each standby level clears them
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 4; i++) begin
        v = $random(seed) & 32'h0000_0077;
        axw(8'(OFS_CH1_CTL + 4 * i), v);
        rc("ctl_rw", 8'(OFS_CH1_CTL + 4 * i), v);
      end
      v = $random(seed) & 32'h0000_00ff;
      axw(OFS_CH0_SEL, v);
      chk("wr_resp", 32'(resp), 32'(RESP_OKAY));
      rc("sel_rw", OFS_CH0_SEL, v);
      @(posedge clk);
      {sb_sw, sb_hw} <= 2'(1 << k);
      repeat (2) @(posedge clk);
      {sb_sw, sb_hw} <= 2'b00;
      for (i = 0; i < 4; i++) rc("ctl_stby", 8'(OFS_CH1_CTL + 4 * i), 0);
    end
    // Channel 0: every code on every lane by rotation
    for (r = 0; r < 4; r++) begin
      sel = 0;
      st = 0;
      for (i = 0; i < 4; i++) begin
        cd[i] = (i + r) % 4;
        sel[2 * i +: 2] = 2'(cd[i]);
        st[i] = (cd[i] != 0 || i == 3);
      end
      axw(OFS_CH0_SEL, sel);
      axw(OFS_IRQ_MASK, r[0] ? 32'h0000_0fff : 32'h0);
      for (i = 0; i < 4; i++) axr(8'(OFS_ICR + 4 * i), base[i]);
      @(posedge clk);
      c10 <= 1;
      tm = cyc;
      @(posedge clk);
      c10 <= 0;
      repeat (3) @(posedge clk);
      p0 <= 4'hF;
      tr = cyc;
      repeat (10) @(posedge clk);
      p0 <= 4'h0;
      tf = cyc;
      for (i = 0; i < 4; i++) axr(8'(OFS_ICR + 4 * i), cap[i]);
      for (i = 0; i < 4; i++) begin
        e = (cd[i] == 0) ? ((i == 3) ? tm + off : int'(base[i])) : ((cd[i] == 1) ? tr + off : tf + off);
        chk("capture", cap[i], 32'(e & 16'hFFFF));
      end
      chk("irq_ch0", {31'd0, irq}, {31'd0, r[0]});
      rc("stat_ch0", OFS_IRQ_STAT, st);
      axw(OFS_IRQ_STAT, 32'h0000_0fff);
      repeat (2) @(negedge clk);
      chk("irq_clr", {31'd0, irq}, 0);
    end
    // Channel 1: low, high, toggle, capture with blocked write
    axw(OFS_CH1_CTL, 32'h21);
    axw(8'(OFS_CH1_CTL + 4), 32'h53);
    axw(8'(OFS_CH1_CTL + 8), 0);
    axw(8'(OFS_CH1_CTL + 12), 0);
    axw(OFS_IRQ_MASK, 32'h0000_0ff0);
    axr(OFS_CNT1, v);
    t = (int'(v) + 100) & 16'hFFFF;
    for (i = 0; i < 3; i++) axw(8'(OFS_GR + 4 * i), 32'(t));
    axw(8'(OFS_GR + 12), 32'h0000_1234);
    rc("gr_capmode_wr", 8'(OFS_GR + 12), 32'(GR_RST));
    rc("gr_wr", OFS_GR, 32'(t));
    repeat (100) @(posedge clk);
    @(negedge clk);
    chk("pin_out", 32'(p1_out), 32'h06);
    chk("pin_oe_n", 32'(p1_oen), 32'h08);
    rc("stat_match", OFS_IRQ_STAT, 32'h070);
    chk("irq_ch1", {31'd0, irq}, 1);
    @(posedge clk);
    p1_drv <= 8'h08;
    tr = cyc;
    repeat (3) @(posedge clk);
    rc("stat_cap", OFS_IRQ_STAT, 32'h0f0);
    axr(8'(OFS_GR + 12), v);
    chk("gr_captured", v, 32'((tr + off) & 16'hFFFF));
    // Falling edge capture on the same lane
    axw(8'(OFS_CH1_CTL + 4), 32'h63);
    @(posedge clk);
    p1_drv <= 8'h00;
    tf = cyc;
    repeat (3) @(posedge clk);
    axr(8'(OFS_GR + 12), v);
    chk("gr_fall", v, 32'((tf + off) & 16'hFFFF));
    final_report();
  end
endmodule
